// ---- logic/pbm_edge.sv ----
// selectable rising/falling edge detector for one interrupt source
`timescale 1ns/100ps
module pbm_edge
	import pbm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic lvl,
	input wire logic fall_sel,
	output logic pulse
);
	logic prev_q;

	// remember last level
	always_ff @(posedge clk or posedge rst)
		if (rst)
			prev_q <= 1'b0;
		else
			prev_q <= lvl;

	// rising unless falling chosen
	always_comb
		pulse = fall_sel ? (prev_q & ~lvl) : (~prev_q & lvl);
endmodule

// ---- logic/pbm_pin_mux.sv ----
// port B and port C pin function multiplexing and input gating
`timescale 1ns/100ps
module pbm_pin_mux
	import pbm_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	// port B pins
	input wire logic [7:0] PB_PIN_IN,
	output logic [7:0] PB_PIN_OUT,
	output logic [7:0] PB_PIN_OE,
	output logic [7:0] PB_PULL_UP,
	output logic [7:0] PB_PULL_DN,
	output logic [7:0] PB_ANALOG_EN,
	// port C pins
	input wire logic [5:0] PC_PIN_IN,
	output logic [5:0] PC_PIN_OUT,
	output logic [5:0] PC_PIN_OE,
	output logic [5:0] PC_PULL_UP,
	output logic [5:0] PC_PULL_DN,
	output logic [5:0] PC_ANALOG_EN,
	// port control from the core
	input wire logic [7:0] PB_DATA,
	input wire logic [7:0] PB_DIR_OUT,
	input wire logic [7:0] PB_PU_EN,
	input wire logic [7:0] PB_PD_EN,
	input wire logic [7:0] PB_DIE,
	input wire logic [5:0] PC_DATA,
	input wire logic [5:0] PC_DIR_OUT,
	input wire logic [5:0] PC_PU_EN,
	input wire logic [5:0] PC_PD_EN,
	input wire logic [5:0] PC_DIE,
	input wire logic [23:0] PB_OUT_SEL,
	input wire logic [17:0] PC_OUT_SEL,
	// peripheral outputs
	input wire logic TIMER3_PULSE_OUT,
	input wire logic TIMER2_PULSE_OUT,
	input wire logic PWM_GEN0_OUT,
	input wire logic PWM_GEN1_OUT,
	input wire logic PWM_GEN2_OUT,
	// analog selections
	input wire logic [3:0] ADC_CHAN_SEL,
	input wire logic ADC_CHAN_EN,
	input wire logic ADC_EXT_REF_SEL,
	input wire logic [2:0] CMP_NEG_SEL,
	input wire logic CMP_EN,
	// external interrupt configuration
	input wire logic IRQ0_SEL_A,
	input wire logic [1:0] IRQ1_SEL,
	input wire logic IRQ0_FALL,
	input wire logic IRQ1_FALL,
	// results
	output logic [7:0] PB_IN_DATA,
	output logic [5:0] PC_IN_DATA,
	output logic WAKE_EVENT,
	output logic EXT_IRQ0_SRC_A,
	output logic EXT_IRQ1_SRC_C,
	output logic EXT_IRQ1_PRIMARY,
	output logic CMP_NEG_SRC4,
	output logic CMP_NEG_SRC5,
	output logic ADC_CHAN11_IN,
	output logic ADC_CHAN12_IN,
	output logic ADC_VREF_EXT
);
	// ====================================================
	// input synchronisation
	logic [7:0] pb_sync;
	logic [5:0] pc_sync;

	pbm_sync #(.W(PB_PINS)) u_sync_pb (
		.clk(CORE_CLK),
		.rst(RST),
		.din(PB_PIN_IN),
		.dout(pb_sync)
	);

	pbm_sync #(.W(PC_PINS)) u_sync_pc (
		.clk(CORE_CLK),
		.rst(RST),
		.din(PC_PIN_IN),
		.dout(pc_sync)
	);

	// ====================================================
	// output source select per pin
	logic [7:0] pb_out_d;
	logic [7:0] pb_alt;
	logic [5:0] pc_out_d;
	logic [5:0] pc_alt;
	logic [7:0] periph_src;

	// index by select code; unused codes read low
	assign periph_src = {2'h0, PWM_GEN2_OUT, PWM_GEN1_OUT, PWM_GEN0_OUT,
		TIMER2_PULSE_OUT, TIMER3_PULSE_OUT, 1'b0};

	genvar gi;
	generate
		for (gi = 0; gi < PB_PINS; gi++)
		begin : g_pb
			logic [2:0] sel;
			logic legal;
			assign sel = PB_OUT_SEL[gi*SEL_W +: SEL_W];
			// an illegal code for this pin falls back to the latch
			assign legal = PB_ALLOW[gi][sel] && (sel != SEL_GPIO);
			assign pb_alt[gi] = legal;
			assign pb_out_d[gi] = legal ? periph_src[sel] : PB_DATA[gi];
		end
		for (gi = 0; gi < PC_PINS; gi++)
		begin : g_pc
			logic [2:0] sel;
			logic legal;
			assign sel = PC_OUT_SEL[gi*SEL_W +: SEL_W];
			assign legal = PC_ALLOW[gi][sel] && (sel != SEL_GPIO);
			assign pc_alt[gi] = legal;
			assign pc_out_d[gi] = legal ? periph_src[sel] : PC_DATA[gi];
		end
	endgenerate

	// ====================================================
	// analog claims per pin
	logic [7:0] pb_ana_d;
	logic [5:0] pc_ana_d;

	always_comb
	begin
		pb_ana_d = '0;
		pc_ana_d = '0;
		if (ADC_CHAN_EN && ADC_CHAN_SEL < 4'h8)
			pb_ana_d[ADC_CHAN_SEL[2:0]] = 1'b1;
		if (ADC_CHAN_EN && ADC_CHAN_SEL == ADC_CH11)
			pc_ana_d[1] = 1'b1;
		if (ADC_CHAN_EN && ADC_CHAN_SEL == ADC_CH12)
			pc_ana_d[2] = 1'b1;
		if (ADC_EXT_REF_SEL)
			pb_ana_d[1] = 1'b1;
		if (CMP_EN && CMP_NEG_SEL == CMP_NEG4)
			pb_ana_d[6] = 1'b1;
		if (CMP_EN && CMP_NEG_SEL == CMP_NEG5)
			pb_ana_d[7] = 1'b1;
	end

	// ====================================================
	// pad drive: alternate output forces the driver on
	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
		begin
			PB_PIN_OUT <= '0;
			PB_PIN_OE <= '0;
			PC_PIN_OUT <= '0;
			PC_PIN_OE <= '0;
		end
		else
		begin
			PB_PIN_OUT <= pb_out_d;
			PB_PIN_OE <= PB_DIR_OUT | pb_alt;
			PC_PIN_OUT <= pc_out_d;
			PC_PIN_OE <= PC_DIR_OUT | pc_alt;
		end

	// pulls are independent; both may be on at once
	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
		begin
			PB_PULL_UP <= '0;
			PB_PULL_DN <= '0;
			PC_PULL_UP <= '0;
			PC_PULL_DN <= '0;
		end
		else
		begin
			PB_PULL_UP <= PB_PU_EN;
			PB_PULL_DN <= PB_PD_EN;
			PC_PULL_UP <= PC_PU_EN;
			PC_PULL_DN <= PC_PD_EN;
		end

	// analog switches to the pads
	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
		begin
			PB_ANALOG_EN <= '0;
			PC_ANALOG_EN <= '0;
		end
		else
		begin
			// enable bit is left to software, leakage is its concern
			PB_ANALOG_EN <= pb_ana_d;
			PC_ANALOG_EN <= pc_ana_d;
		end

	// ====================================================
	// digital input gating
	logic [7:0] pb_in_d;
	logic [5:0] pc_in_d;
	assign pb_in_d = pb_sync & PB_DIE;
	assign pc_in_d = pc_sync & PC_DIE;

	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
		begin
			PB_IN_DATA <= '0;
			PC_IN_DATA <= '0;
		end
		else
		begin
			PB_IN_DATA <= pb_in_d;
			PC_IN_DATA <= pc_in_d;
		end

	// ====================================================
	// toggle wake-up, gated inputs only
	logic [7:0] pb_prev_q;
	logic [5:0] pc_prev_q;
	logic [7:0] pb_tog;
	logic [5:0] pc_tog;

	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
		begin
			pb_prev_q <= '0;
			pc_prev_q <= '0;
		end
		else
		begin
			pb_prev_q <= pb_in_d;
			pc_prev_q <= pc_in_d;
		end

	// enable masks both samples so a disable itself cannot wake
	assign pb_tog = (pb_in_d ^ pb_prev_q) & PB_DIE;
	assign pc_tog = (pc_in_d ^ pc_prev_q) & PC_DIE;

	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
			WAKE_EVENT <= 1'b0;
		else
			WAKE_EVENT <= |pb_tog || |pc_tog;

	// ====================================================
	// external interrupt sources
	logic irq0_a_d;
	logic irq1_c_d;
	logic irq1_p_d;

	pbm_edge u_edge_b5 (
		.clk(CORE_CLK),
		.rst(RST),
		.lvl(pb_in_d[5]),
		.fall_sel(IRQ0_FALL),
		.pulse(irq0_a_d)
	);

	pbm_edge u_edge_b6 (
		.clk(CORE_CLK),
		.rst(RST),
		.lvl(pb_in_d[6]),
		.fall_sel(IRQ1_FALL),
		.pulse(irq1_c_d)
	);

	pbm_edge u_edge_b0 (
		.clk(CORE_CLK),
		.rst(RST),
		.lvl(pb_in_d[0]),
		.fall_sel(IRQ1_FALL),
		.pulse(irq1_p_d)
	);

	// one-cycle request pulses to the interrupt controller
	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
		begin
			EXT_IRQ0_SRC_A <= 1'b0;
			EXT_IRQ1_SRC_C <= 1'b0;
			EXT_IRQ1_PRIMARY <= 1'b0;
		end
		else
		begin
			EXT_IRQ0_SRC_A <= irq0_a_d && IRQ0_SEL_A == IRQ0_SRC_A;
			EXT_IRQ1_SRC_C <= irq1_c_d && IRQ1_SEL == IRQ1_SRC_C;
			EXT_IRQ1_PRIMARY <= irq1_p_d && IRQ1_SEL == IRQ1_PRIMARY;
		end

	// ====================================================
	// analog path enables
	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
		begin
			CMP_NEG_SRC4 <= 1'b0;
			CMP_NEG_SRC5 <= 1'b0;
			ADC_CHAN11_IN <= 1'b0;
			ADC_CHAN12_IN <= 1'b0;
			ADC_VREF_EXT <= 1'b0;
		end
		else
		begin
			CMP_NEG_SRC4 <= pb_ana_d[6] && CMP_EN;
			CMP_NEG_SRC5 <= pb_ana_d[7] && CMP_EN;
			ADC_CHAN11_IN <= ADC_CHAN_EN && ADC_CHAN_SEL == ADC_CH11;
			ADC_CHAN12_IN <= ADC_CHAN_EN && ADC_CHAN_SEL == ADC_CH12;
			ADC_VREF_EXT <= ADC_EXT_REF_SEL;
		end

	// ====================================================
	// checks
	chk_input_gate_b: assert property (@(posedge CORE_CLK) disable iff (RST)
		!PB_DIE[3] |=> !PB_IN_DATA[3]) else $error("gated input seen");
	chk_input_gate_c5: assert property (@(posedge CORE_CLK) disable iff (RST)
		!PC_DIE[5] |=> !PC_IN_DATA[5]) else $error("pc5 input seen");
	chk_wake_gated: assert property (@(posedge CORE_CLK) disable iff (RST)
		(PB_DIE == 8'h00 && PC_DIE == 6'h00) |=> !WAKE_EVENT)
		else $error("wake while gated");
	chk_pull_indep: assert property (@(posedge CORE_CLK) disable iff (RST)
		1'b1 |=> PB_PULL_UP == $past(PB_PU_EN) && PC_PULL_DN == $past(PC_PD_EN))
		else $error("pull mismatch");
	chk_tm3_route: assert property (@(posedge CORE_CLK) disable iff (RST)
		PB_OUT_SEL[23:21] == SEL_TM3 |=> PB_PIN_OE[7] &&
		PB_PIN_OUT[7] == $past(TIMER3_PULSE_OUT)) else $error("tm3 route");
	chk_tm2_route: assert property (@(posedge CORE_CLK) disable iff (RST)
		PB_OUT_SEL[8:6] == SEL_TM2 |=> PB_PIN_OUT[2] == $past(TIMER2_PULSE_OUT))
		else $error("tm2 route");
	chk_pg0_route: assert property (@(posedge CORE_CLK) disable iff (RST)
		PC_OUT_SEL[8:6] == SEL_PG0 |=> PC_PIN_OUT[2] == $past(PWM_GEN0_OUT))
		else $error("pg0 route");
	chk_pg1_route: assert property (@(posedge CORE_CLK) disable iff (RST)
		PC_OUT_SEL[11:9] == SEL_PG1 |=> PC_PIN_OUT[3] == $past(PWM_GEN1_OUT))
		else $error("pg1 route");
	chk_pg2_route: assert property (@(posedge CORE_CLK) disable iff (RST)
		PC_OUT_SEL[2:0] == SEL_PG2 |=> PC_PIN_OUT[0] == $past(PWM_GEN2_OUT))
		else $error("pg2 route");
	chk_gpio_latch: assert property (@(posedge CORE_CLK) disable iff (RST)
		PB_OUT_SEL[2:0] == SEL_GPIO |=> PB_PIN_OUT[0] == $past(PB_DATA[0]) &&
		PB_PIN_OE[0] == $past(PB_DIR_OUT[0])) else $error("gpio drive");
	chk_adc_map: assert property (@(posedge CORE_CLK) disable iff (RST)
		ADC_CHAN_EN && ADC_CHAN_SEL == 4'h5 |=> PB_ANALOG_EN[5])
		else $error("adc map");
	chk_cmp_src5: assert property (@(posedge CORE_CLK) disable iff (RST)
		CMP_EN && CMP_NEG_SEL == CMP_NEG5 |=> CMP_NEG_SRC5 && PB_ANALOG_EN[7])
		else $error("cmp src5");
	chk_vref_pin: assert property (@(posedge CORE_CLK) disable iff (RST)
		ADC_EXT_REF_SEL |=> ADC_VREF_EXT && PB_ANALOG_EN[1])
		else $error("vref pin");
	chk_irq0_rise: assert property (@(posedge CORE_CLK) disable iff (RST)
		IRQ0_SEL_A && !IRQ0_FALL && $rose(pb_in_d[5]) |=> EXT_IRQ0_SRC_A)
		else $error("irq0 edge");
	chk_irq1_fall: assert property (@(posedge CORE_CLK) disable iff (RST)
		IRQ1_SEL == IRQ1_SRC_C && IRQ1_FALL && $fell(pb_in_d[6])
		|=> EXT_IRQ1_SRC_C) else $error("irq1 edge");
endmodule

// ---- logic/pbm_sync.sv ----
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module pbm_sync
	import pbm_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			s1_q <= '0;
			dout <= '0;
		end
		else
		begin
			s1_q <= din;
			dout <= s1_q;
		end
endmodule

// ---- shared/pbm_pkg.sv ----
// constants shared by the port B/C pin function mux
package pbm_pkg;
	localparam int PB_PINS = 8;
	localparam int PC_PINS = 6;
	// output source select codes, one per pin
	localparam int SEL_W = 3;
	localparam logic [2:0] SEL_GPIO = 3'h0;
	localparam logic [2:0] SEL_TM3 = 3'h1;
	localparam logic [2:0] SEL_TM2 = 3'h2;
	localparam logic [2:0] SEL_PG0 = 3'h3;
	localparam logic [2:0] SEL_PG1 = 3'h4;
	localparam logic [2:0] SEL_PG2 = 3'h5;
	// per-pin legal source masks, bit k set means code k allowed
	localparam logic [7:0] PB_ALLOW [8] = '{
		8'h01, 8'h01, 8'h25, 8'h21, 8'h0D, 8'h0B, 8'h13, 8'h13};
	localparam logic [7:0] PC_ALLOW [6] = '{
		8'h21, 8'h01, 8'h09, 8'h11, 8'h01, 8'h01};
	// adc channel map
	localparam logic [3:0] ADC_CH11 = 4'hB;
	localparam logic [3:0] ADC_CH12 = 4'hC;
	// comparator negative-input codes
	localparam logic [2:0] CMP_NEG4 = 3'h4;
	localparam logic [2:0] CMP_NEG5 = 3'h5;
	// external interrupt source selects
	localparam logic [1:0] IRQ1_PRIMARY = 2'h0;
	localparam logic [1:0] IRQ1_SRC_C = 2'h2;
	localparam logic IRQ0_SRC_A = 1'h1;
	// reset values
	localparam logic [7:0] PB_DIE_RST = 8'hFF;
	localparam logic [5:0] PC_DIE_RST = 6'h3F;
endpackage

// ---- sim/pbm_board.sv ----
// board-side pad model that resolves each pin level
`timescale 1ns/100ps
module pbm_board
#(
	parameter int W = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	input wire logic [W-1:0] pull_up,
	input wire logic [W-1:0] pull_dn,
	input wire logic [W-1:0] ext,
	input wire logic [W-1:0] ext_en,
	output logic [W-1:0] pin_lvl
);
	logic [W-1:0] last_q;
	// ==========================================
	// wire resolution
	// chip drive wins, then board drive, then pulls; a bare pad wanders
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			if (pin_oe[i])
				pin_lvl[i] = pin_out[i];
			else if (ext_en[i])
				pin_lvl[i] = ext[i];
			else if (pull_up[i])
				pin_lvl[i] = 1'b1;
			else if (pull_dn[i])
				pin_lvl[i] = 1'b0;
			else
				pin_lvl[i] = ~last_q[i]; // never holds a stale level
		end
	end
	// last level, used to flip floating pads every cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			last_q <= '0;
		else
			last_q <= pin_lvl;
	end
endmodule

// ---- sim/pbm_pin_mux_tb.sv ----
// self-checking bench for the port B/C pin function mux
`timescale 1ns/100ps
module pbm_pin_mux_tb
	import pbm_pkg::*;
;
	logic CORE_CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] PB_PIN_IN, PB_PIN_OUT, PB_PIN_OE, PB_PULL_UP, PB_PULL_DN;
	logic [7:0] PB_ANALOG_EN, PB_IN_DATA, PB_DATA, PB_DIR_OUT, PB_PU_EN;
	logic [7:0] PB_PD_EN, PB_DIE, b_ext, b_ext_en;
	logic [5:0] PC_PIN_IN, PC_PIN_OUT, PC_PIN_OE, PC_PULL_UP, PC_PULL_DN;
	logic [5:0] PC_ANALOG_EN, PC_IN_DATA, PC_DATA, PC_DIR_OUT, PC_PU_EN;
	logic [5:0] PC_PD_EN, PC_DIE, c_ext;
	logic [23:0] PB_OUT_SEL;
	logic [17:0] PC_OUT_SEL;
	logic TIMER3_PULSE_OUT, TIMER2_PULSE_OUT, PWM_GEN0_OUT, PWM_GEN1_OUT;
	logic PWM_GEN2_OUT, ADC_CHAN_EN, ADC_EXT_REF_SEL, CMP_EN, IRQ0_SEL_A;
	logic IRQ0_FALL, IRQ1_FALL, WAKE_EVENT, EXT_IRQ0_SRC_A, EXT_IRQ1_SRC_C;
	logic EXT_IRQ1_PRIMARY, CMP_NEG_SRC4, CMP_NEG_SRC5, ADC_CHAN11_IN;
	logic ADC_CHAN12_IN, ADC_VREF_EXT;
	logic [3:0] ADC_CHAN_SEL;
	logic [2:0] CMP_NEG_SEL;
	logic [1:0] IRQ1_SEL;
	logic [4:0] ana_outs;
	// analog path enables gathered so one compare covers them all
	assign ana_outs = {CMP_NEG_SRC4, CMP_NEG_SRC5, ADC_CHAN11_IN,
		ADC_CHAN12_IN, ADC_VREF_EXT};
	int bad_count = 0, n_tests = 0, n_wake, n_i0, n_i1c, n_i1p;
	// legal routes: port bit 7, pin 6:4, source code 2:0
	localparam logic [7:0] ALT_TAB [14] = '{8'h22, 8'h25, 8'h35, 8'h42,
		8'h43, 8'h51, 8'h53, 8'h61, 8'h64, 8'h71, 8'h74, 8'h85, 8'hA3, 8'hB4};
	// ==========================================
	// design and board
	pbm_pin_mux pbm_pin_mux_i (.CORE_CLK, .RST, .PB_PIN_IN, .PB_PIN_OUT,
		.PB_PIN_OE, .PB_PULL_UP, .PB_PULL_DN, .PB_ANALOG_EN, .PC_PIN_IN,
		.PC_PIN_OUT, .PC_PIN_OE, .PC_PULL_UP, .PC_PULL_DN, .PC_ANALOG_EN,
		.PB_DATA, .PB_DIR_OUT, .PB_PU_EN, .PB_PD_EN, .PB_DIE, .PC_DATA,
		.PC_DIR_OUT, .PC_PU_EN, .PC_PD_EN, .PC_DIE, .PB_OUT_SEL, .PC_OUT_SEL,
		.TIMER3_PULSE_OUT, .TIMER2_PULSE_OUT, .PWM_GEN0_OUT, .PWM_GEN1_OUT,
		.PWM_GEN2_OUT, .ADC_CHAN_SEL, .ADC_CHAN_EN, .ADC_EXT_REF_SEL,
		.CMP_NEG_SEL, .CMP_EN, .IRQ0_SEL_A, .IRQ1_SEL, .IRQ0_FALL, .IRQ1_FALL,
		.PB_IN_DATA, .PC_IN_DATA, .WAKE_EVENT, .EXT_IRQ0_SRC_A,
		.EXT_IRQ1_SRC_C, .EXT_IRQ1_PRIMARY, .CMP_NEG_SRC4, .CMP_NEG_SRC5,
		.ADC_CHAN11_IN, .ADC_CHAN12_IN, .ADC_VREF_EXT);
	pbm_board #(.W(8)) pbm_board_b_i (.clk(CORE_CLK), .rst(RST),
		.pin_out(PB_PIN_OUT), .pin_oe(PB_PIN_OE), .pull_up(PB_PULL_UP),
		.pull_dn(PB_PULL_DN), .ext(b_ext), .ext_en(b_ext_en),
		.pin_lvl(PB_PIN_IN));
	pbm_board #(.W(6)) pbm_board_c_i (.clk(CORE_CLK), .rst(RST),
		.pin_out(PC_PIN_OUT), .pin_oe(PC_PIN_OE), .pull_up(PC_PULL_UP),
		.pull_dn(PC_PULL_DN), .ext(c_ext), .ext_en(6'h3F),
		.pin_lvl(PC_PIN_IN));
	always #2 CORE_CLK = ~CORE_CLK;
	// ==========================================
	// helpers
	// inputs move 1 ns after the edge, outputs are read there too
	task tick(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// count one-cycle pulses over a window long enough for the sync chain
	task watch(input int n);
		n_wake = 0;
		n_i0 = 0;
		n_i1c = 0;
		n_i1p = 0;
		repeat (n)
		begin
			tick(1);
			if (WAKE_EVENT === 1'b1) n_wake++;
			if (EXT_IRQ0_SRC_A === 1'b1) n_i0++;
			if (EXT_IRQ1_SRC_C === 1'b1) n_i1c++;
			if (EXT_IRQ1_PRIMARY === 1'b1) n_i1p++;
		end
	endtask
	task step_b(input logic [7:0] v, input int w, i0, i1c, i1p);
		b_ext = v;
		watch(6);
		chk("wake", n_wake, w);
		chk("irq0_a", n_i0, i0);
		chk("irq1_c", n_i1c, i1c);
		chk("irq1_p", n_i1p, i1p);
	endtask
	task set_per(input logic [2:0] code, input logic v);
		{PWM_GEN2_OUT, PWM_GEN1_OUT, PWM_GEN0_OUT, TIMER2_PULSE_OUT,
			TIMER3_PULSE_OUT} = v ? 5'h01 << (code - 1) : ~(5'h01 << (code - 1));
	endtask
	// ==========================================
	// scenarios
	// pins 2,3 float on pulls, 0,1 board driven, 4-7 looped back outputs
	task t_gpio;
		PB_DIR_OUT = 8'hF0;
		PB_DATA = 8'h3C;
		b_ext = 8'h0A;
		b_ext_en = 8'hF3;
		PC_DIR_OUT = 6'h07;
		PC_DATA = 6'h15;
		c_ext = 6'h28;
		PB_PU_EN = 8'hA5;
		PB_PD_EN = 8'h0F;
		PC_PU_EN = 6'h21;
		PC_PD_EN = 6'h23;
		tick(1);
		chk("pb_oe", PB_PIN_OE, 8'hF0);
		chk("pb_out", PB_PIN_OUT & 8'hF0, 8'h30);
		chk("pc_oe", PC_PIN_OE, 6'h07);
		chk("pc_out", PC_PIN_OUT & 6'h07, 6'h05);
		chk("pulls", {PB_PULL_UP, PB_PULL_DN, PC_PULL_UP, PC_PULL_DN}, 28'hA50F863);
		tick(4);
		chk("pb_in", PB_IN_DATA, 8'h36);
		chk("pc_in", PC_IN_DATA, 6'h2D);
		{PB_DIR_OUT, PC_DIR_OUT, PB_PU_EN, PB_PD_EN, PC_PU_EN, PC_PD_EN} = '0;
		{b_ext, c_ext} = '0;
		b_ext_en = 8'hFF;
		tick(6);
	endtask
	// mode changes settle outside the counted windows
	task t_irq;
		IRQ0_SEL_A = IRQ0_SRC_A;
		IRQ1_SEL = IRQ1_SRC_C;
		tick(6);
		step_b(8'h20, 1, 1, 0, 0);
		step_b(8'h00, 1, 0, 0, 0);
		IRQ0_FALL = 1'b1;
		tick(6);
		step_b(8'h20, 1, 0, 0, 0);
		step_b(8'h00, 1, 1, 0, 0);
		step_b(8'h40, 1, 0, 1, 0);
		IRQ1_FALL = 1'b1;
		tick(6);
		step_b(8'h00, 1, 0, 1, 0);
		step_b(8'h40, 1, 0, 0, 0);
		IRQ1_SEL = IRQ1_PRIMARY;
		tick(6);
		step_b(8'h00, 1, 0, 0, 0);
		step_b(8'h01, 1, 0, 0, 0);
		step_b(8'h00, 1, 0, 0, 1);
		{IRQ0_SEL_A, IRQ0_FALL, IRQ1_FALL} = '0;
		tick(6);
		step_b(8'h20, 1, 0, 0, 0);
		b_ext = 8'h00;
		tick(6);
	endtask
	task t_gate;
		PB_DIE = 8'hFE;
		PC_DIE = 6'h1F;
		tick(6);
		step_b(8'h01, 0, 0, 0, 0);
		chk("pb_in0", PB_IN_DATA[0], 1'b0);
		c_ext = 6'h20;
		watch(6);
		chk("wake_c5", n_wake, 0);
		chk("pc_in5", PC_IN_DATA[5], 1'b0);
		{b_ext, c_ext} = '0;
		tick(6);
		PB_DIE = PB_DIE_RST;
		PC_DIE = PC_DIE_RST;
		tick(6);
		c_ext = 6'h20;
		watch(6);
		chk("wake_c5", n_wake, 1);
		chk("pc_in5", PC_IN_DATA[5], 1'b1);
		step_b(8'h01, 1, 0, 0, 1);
		{b_ext, c_ext} = '0;
		tick(6);
	endtask
	// the latch is driven opposite to the peripheral to tell them apart
	task t_alt;
		logic [7:0] e;
		logic v;
		for (int i = 0; i < 14; i++)
		begin
			e = ALT_TAB[i];
			{PB_OUT_SEL, PC_OUT_SEL} = '0;
			if (e[7])
				PC_OUT_SEL[e[6:4] * 3 +: 3] = e[2:0];
			else
				PB_OUT_SEL[e[6:4] * 3 +: 3] = e[2:0];
			for (int k = 0; k < 2; k++)
			begin
				v = ~k[0];
				set_per(e[2:0], v);
				PB_DATA = {8{~v}};
				PC_DATA = {6{~v}};
				tick(1);
				chk("alt_oe", e[7] ? PC_PIN_OE[e[6:4]] : PB_PIN_OE[e[6:4]], 1'b1);
				chk("alt_out", e[7] ? PC_PIN_OUT[e[6:4]] : PB_PIN_OUT[e[6:4]], v);
			end
		end
		PB_OUT_SEL = {21'h0, SEL_TM3};
		PC_OUT_SEL = '0;
		PB_DATA = 8'h01;
		TIMER3_PULSE_OUT = 1'b0;
		tick(1);
		chk("bad_sel_oe", PB_PIN_OE[0], 1'b0);
		chk("bad_sel_out", PB_PIN_OUT[0], 1'b1);
		{PB_OUT_SEL, PB_DATA, PC_DATA} = '0;
		tick(6);
	endtask
	task t_analog;
		PB_DIE = 8'h00;
		ADC_CHAN_EN = 1'b1;
		for (int ch = 0; ch < 8; ch++)
		begin
			ADC_CHAN_SEL = ch[3:0];
			tick(1);
			chk("adc_pb", PB_ANALOG_EN, 8'h01 << ch);
			chk("ana_outs", ana_outs, 5'h00);
		end
		ADC_CHAN_SEL = ADC_CH11;
		tick(1);
		chk("adc_11", PC_ANALOG_EN, 6'h02);
		chk("ana_outs", ana_outs, 5'h04);
		ADC_CHAN_SEL = ADC_CH12;
		tick(1);
		chk("adc_12", PC_ANALOG_EN, 6'h04);
		chk("ana_outs", ana_outs, 5'h02);
		// a channel with no pin here claims nothing
		ADC_CHAN_SEL = 4'hD;
		tick(1);
		chk("adc_none", {PB_ANALOG_EN, PC_ANALOG_EN}, 14'h0000);
		chk("ana_outs", ana_outs, 5'h00);
		ADC_CHAN_EN = 1'b0;
		ADC_EXT_REF_SEL = 1'b1;
		tick(1);
		chk("vref", PB_ANALOG_EN, 8'h02);
		chk("ana_outs", ana_outs, 5'h01);
		ADC_EXT_REF_SEL = 1'b0;
		CMP_EN = 1'b1;
		CMP_NEG_SEL = CMP_NEG4;
		tick(1);
		chk("cmp4", PB_ANALOG_EN, 8'h40);
		chk("ana_outs", ana_outs, 5'h10);
		CMP_NEG_SEL = CMP_NEG5;
		tick(1);
		chk("cmp5", PB_ANALOG_EN, 8'h80);
		chk("ana_outs", ana_outs, 5'h08);
		CMP_EN = 1'b0;
		PB_DIE = PB_DIE_RST;
		tick(6);
	endtask
	// ==========================================
	// main sequence and watchdog
	initial
	begin
		{PB_DATA, PB_DIR_OUT, PB_PU_EN, PB_PD_EN, b_ext} = '0;
		{PC_DATA, PC_DIR_OUT, PC_PU_EN, PC_PD_EN, c_ext} = '0;
		{PB_OUT_SEL, PC_OUT_SEL, ADC_CHAN_SEL, CMP_NEG_SEL, IRQ1_SEL} = '0;
		{ADC_CHAN_EN, ADC_EXT_REF_SEL, CMP_EN, IRQ0_SEL_A} = '0;
		{IRQ0_FALL, IRQ1_FALL} = '0;
		set_per(SEL_TM3, 1'b0);
		b_ext_en = 8'hFF;
		PB_DIE = PB_DIE_RST;
		PC_DIE = PC_DIE_RST;
		repeat (20) @(posedge CORE_CLK);
		#1;
		RST = 1'b0;
		tick(1);
		t_gpio();
		t_irq();
		t_gate();
		t_alt();
		t_analog();
		finish_test();
	end
	// the tests need well under a thousand cycles
	initial
	begin
		#(4000 * 4);
		bad_count++;
		finish_test();
	end
endmodule
